// ==== logic/ssr_pkg.sv ====
// Package of constants and types for the supply supervisor reset logic
package ssr_pkg;
  localparam int unsigned CLK_HZ          = 125000000;
  localparam int unsigned CLK_PERIOD_NS   = 8;
  // Time base tick period
  localparam int unsigned TICK_US         = 1;
  localparam int unsigned TICK_CYC        = (TICK_US * 1000) / CLK_PERIOD_NS;
  // Reset timeout, nominal
  localparam int unsigned RST_TIMEOUT_MS  = 200;
  localparam int unsigned RST_TIMEOUT_TK  = RST_TIMEOUT_MS * 1000 / TICK_US;
  // Power-down and sense response limits
  localparam int unsigned PD_DELAY_US     = 5;
  localparam int unsigned PD_DELAY_CYC    = (PD_DELAY_US * 1000) / CLK_PERIOD_NS;
  // Glitch width to reject, least time so round up
  localparam int unsigned GLITCH_NS       = 30;
  localparam int unsigned GLITCH_CYC      = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Internal write time, longest so round down
  localparam int unsigned WRITE_TIME_MS   = 5;
  localparam int unsigned WRITE_TIME_TK   = WRITE_TIME_MS * 1000 / TICK_US;
  // Watchdog interval
  localparam int unsigned WDOG_MS         = 1600;
  localparam int unsigned WDOG_TK         = WDOG_MS * 1000 / TICK_US;
  localparam int unsigned TMR_W           = 21;
  localparam logic [TMR_W-1:0] TMR_ZERO   = 21'h0;

  typedef enum logic [1:0] {ST_HOLD, ST_TIMEOUT, ST_RUN} ssr_state_t;
endpackage : ssr_pkg

// ==== logic/ssr_tick_gen.sv ====
// Free-running time-base tick generator
`timescale 1ns/1ps
module ssr_tick_gen #(
  parameter int unsigned DIV = 125
) (
  input  wire logic i_clk,  // Clock
  input  wire logic i_rst,  // Sync reset
  output logic      o_tick  // One-cycle tick
);
  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_q;
  wire          wrap = (cnt_q == LAST);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
      o_tick <= wrap;
    end
  end
endmodule : ssr_tick_gen

// ==== logic/ssr_supervisor.sv ====
// Supply supervisor: reset timing, manual reset, watchdog, aux low, write lockout
// Operation
// (R1) Hold reset, then release after 200 ms
// (R2) Supply drop asserts reset within 5 us
// (R3) Ignore supply dips up to 30 ns
// (R4) Falling edge on reset pin restarts timeout; pin falls are masked while reset is driven, so only a fall in run starts one
// (R5) External reset gives at least 200 ms
// (R6) Aux low output follows sense within 5 us
// (R7) Write cycle blocks bus up to 5 ms
// (R8) Host waits 270 ms before memory access
// (R9) Reset aborts access, lets write finish
// (R10) Watchdog resets after 1.6 s idle
// (R11) Watchdog held cleared during reset
// (R12) Both reset pins from one state
// (R13) Timeouts count a free-running tick
`timescale 1ns/1ps
module ssr_supervisor
  import ssr_pkg::*;
#(
  parameter int unsigned RST_TK   = ssr_pkg::RST_TIMEOUT_TK,  // Reset timeout ticks
  parameter int unsigned WR_TK    = ssr_pkg::WRITE_TIME_TK,   // Write cycle ticks
  parameter int unsigned WD_TK    = ssr_pkg::WDOG_TK,         // Watchdog ticks
  parameter int unsigned TICK_DIV = ssr_pkg::TICK_CYC,        // Clocks per tick
  parameter bit          WDOG_EN  = 1'b1                      // Watchdog variant
) (
  input  wire logic I_CLK,          // 125 MHz clock
  input  wire logic I_RST,          // Sync reset, active high
  input  wire logic I_SUPPLY_OK,    // Supply above threshold
  input  wire logic I_SENSE_LOW,    // Aux sense below 1.25 V
  input  wire logic I_RST_N_PIN,    // Level seen on reset pin
  input  wire logic I_WDOG_KICK,    // Watchdog kick input
  input  wire logic I_WR_STOP,      // Valid stop ending a write
  output logic      O_RST_N_OE,     // Drive active-low reset pin low
  output logic      O_RST_OE,       // Drive active-high reset pin high
  output logic      O_AUX_LOW_OE,   // Drive aux low output low
  output logic      O_MEM_BLOCK,    // Memory bus disabled
  output logic      O_MEM_ABORT,    // Abort transaction in progress
  output logic      O_WR_BUSY       // Internal write running
);
  import ssr_pkg::*;

  localparam int unsigned GW = (GLITCH_CYC > 1) ? $clog2(GLITCH_CYC + 1) : 1;
  localparam logic [GW-1:0]    GLITCH_LIM = GW'(GLITCH_CYC);
  localparam logic [TMR_W-1:0] RST_LAST   = TMR_W'(RST_TK - 1);
  localparam logic [TMR_W-1:0] WR_LAST    = TMR_W'(WR_TK - 1);
  localparam logic [TMR_W-1:0] WD_LAST    = TMR_W'(WD_TK - 1);

  function automatic logic [TMR_W-1:0] tmr_step(input logic [TMR_W-1:0] v, input logic t);
    tmr_step = t ? TMR_W'(v + 1'b1) : v;
  endfunction : tmr_step

  ssr_state_t       state_q, state_d;
  logic [GW-1:0]    low_cnt_q;
  logic             sup_bad_q;
  logic             pin_q;
  logic             kick_q;
  logic [TMR_W-1:0] rst_tmr_q, wr_tmr_q, wd_tmr_q;
  logic             wr_busy_q;
  logic             tick;

  ssr_tick_gen #(.DIV(TICK_DIV)) u_tick (
    .i_clk  (I_CLK),
    .i_rst  (I_RST),
    .o_tick (tick)
  );

  // Supply low must persist past the glitch width before it counts
  wire sup_low    = !I_SUPPLY_OK;
  wire glitch_out = (low_cnt_q == GLITCH_LIM);  // R3
  wire pin_fall   = pin_q && !I_RST_N_PIN && !O_RST_N_OE;  // R4
  wire kick_edge  = (I_WDOG_KICK != kick_q);  // R10
  wire wd_expire  = WDOG_EN && tick && (wd_tmr_q == WD_LAST) && (state_q == ST_RUN);  // R10
  wire rst_done   = tick && (rst_tmr_q == RST_LAST);  // R1
  wire in_reset   = (state_d != ST_RUN);  // R12
  wire wr_start   = I_WR_STOP && !wr_busy_q && !in_reset;  // R9
  wire wr_done    = wr_busy_q && tick && (wr_tmr_q == WR_LAST);  // R7

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HOLD:    if (!sup_bad_q) state_d = ST_TIMEOUT;  // R1
      ST_TIMEOUT: if (rst_done) state_d = ST_RUN;  // R1
      ST_RUN:     if (pin_fall || wd_expire) state_d = ST_TIMEOUT;  // R5
      default:    state_d = ST_HOLD;
    endcase
    if (state_q == ST_TIMEOUT && pin_fall) state_d = ST_TIMEOUT;  // R4
    if (sup_bad_q) state_d = ST_HOLD;  // R2
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      low_cnt_q <= '0;
      sup_bad_q <= 1'b1;
    end else begin
      low_cnt_q <= !sup_low ? '0 : (glitch_out ? low_cnt_q : low_cnt_q + 1'b1);  // R3
      sup_bad_q <= sup_low && (glitch_out || sup_bad_q);  // R2
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_q   <= ST_HOLD;
      pin_q     <= 1'b1;
      kick_q    <= 1'b0;
      rst_tmr_q <= TMR_ZERO;
    end else begin
      state_q   <= state_d;
      pin_q     <= I_RST_N_PIN;
      kick_q    <= I_WDOG_KICK;
      // Timer held clear outside timeout, so it restarts on entry; pin falls are masked while reset is driven
      if (state_q != ST_TIMEOUT || pin_fall) rst_tmr_q <= TMR_ZERO;  // R4
      else rst_tmr_q <= tmr_step(rst_tmr_q, tick);  // R13
    end
  end

  // Watchdog counts only while out of reset
  always_ff @(posedge I_CLK) begin
    if (I_RST || in_reset || kick_edge) wd_tmr_q <= TMR_ZERO;  // R11
    else wd_tmr_q <= tmr_step(wd_tmr_q, tick);  // R10
  end

  // A write under way runs to completion even if reset arrives
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      wr_busy_q <= 1'b0;
      wr_tmr_q  <= TMR_ZERO;
    end else begin
      if (wr_start) wr_busy_q <= 1'b1;  // R7
      else if (wr_done) wr_busy_q <= 1'b0;  // R9
      wr_tmr_q <= wr_busy_q ? tmr_step(wr_tmr_q, tick) : TMR_ZERO;  // R7
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_RST_N_OE   <= 1'b1;
      O_RST_OE     <= 1'b1;
      O_AUX_LOW_OE <= 1'b0;
      O_MEM_BLOCK  <= 1'b1;
      O_MEM_ABORT  <= 1'b1;
      O_WR_BUSY    <= 1'b0;
    end else begin
      O_RST_N_OE   <= in_reset;  // R12
      O_RST_OE     <= in_reset;  // R12
      O_AUX_LOW_OE <= I_SENSE_LOW;  // R6
      O_MEM_BLOCK  <= in_reset || wr_busy_q || wr_start;  // R9
      O_MEM_ABORT  <= in_reset;  // R9
      O_WR_BUSY    <= wr_busy_q || wr_start;  // R7
    end
  end

  property p_glitch_reject;
    @(posedge I_CLK) disable iff (I_RST)
      (state_q == ST_RUN && I_SUPPLY_OK) ##1 (!I_SUPPLY_OK [*3]) ##1 I_SUPPLY_OK
        |-> ##1 (!sup_bad_q && (state_q != ST_HOLD));
  endproperty
  a_glitch_reject: assert property (p_glitch_reject) else $error("Short dip caused reset"); // R3

  property p_pd_delay;
    @(posedge I_CLK) disable iff (I_RST)
      (!I_SUPPLY_OK [*8]) |-> ##[0:2] O_RST_N_OE;
  endproperty
  a_pd_delay: assert property (p_pd_delay) else $error("Reset late after supply drop"); // R2

  property p_both_pins;
    @(posedge I_CLK) disable iff (I_RST) O_RST_N_OE == O_RST_OE;
  endproperty
  a_both_pins: assert property (p_both_pins) else $error("Reset pins disagree"); // R12

  property p_aux;
    @(posedge I_CLK) disable iff (I_RST) $rose(I_SENSE_LOW) |=> O_AUX_LOW_OE;
  endproperty
  a_aux: assert property (p_aux) else $error("Aux low output late"); // R6

  property p_manual;
    @(posedge I_CLK) disable iff (I_RST) (state_q == ST_RUN && pin_fall) |=> ##1 O_RST_N_OE;
  endproperty
  a_manual: assert property (p_manual) else $error("Manual reset missed"); // R5

  property p_wd_hold;
    @(posedge I_CLK) disable iff (I_RST) O_RST_N_OE |-> wd_tmr_q == TMR_ZERO;
  endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("Watchdog ran during reset"); // R11

  property p_no_wr_in_rst;
    @(posedge I_CLK) disable iff (I_RST) (in_reset && !wr_busy_q) |=> !wr_busy_q;
  endproperty
  a_no_wr_in_rst: assert property (p_no_wr_in_rst) else $error("Write began in reset"); // R9

  property p_wr_block;
    @(posedge I_CLK) disable iff (I_RST) wr_busy_q |=> O_MEM_BLOCK && O_WR_BUSY;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("Bus open during write"); // R7

  property p_release;
    @(posedge I_CLK) disable iff (I_RST) (state_q == ST_TIMEOUT && rst_done && !sup_bad_q
      && !pin_fall) |=> !O_RST_N_OE;
  endproperty
  a_release: assert property (p_release) else $error("Reset not released"); // R1

  c_release: cover property (@(posedge I_CLK) $fell(O_RST_N_OE));
  c_manual:  cover property (@(posedge I_CLK) state_q == ST_RUN && pin_fall);
  c_wdog:    cover property (@(posedge I_CLK) wd_expire);
  c_write:   cover property (@(posedge I_CLK) wr_done);
  c_pdown:   cover property (@(posedge I_CLK) state_q == ST_RUN && sup_bad_q);

  // Abort must track the reset pins, or a host could slip in at release
  property p_abort;
    @(posedge I_CLK) disable iff (I_RST) O_MEM_ABORT == O_RST_N_OE;
  endproperty
  a_abort: assert property (p_abort) else $error("Abort out of step with reset"); // R9

  property p_wd_fire;
    @(posedge I_CLK) disable iff (I_RST) wd_expire |=> O_RST_N_OE;
  endproperty
  a_wd_fire: assert property (p_wd_fire) else $error("Watchdog expiry missed"); // R10

  property p_kick_clear;
    @(posedge I_CLK) disable iff (I_RST) kick_edge |=> wd_tmr_q == TMR_ZERO;
  endproperty
  a_kick_clear: assert property (p_kick_clear) else $error("Kick left watchdog running"); // R10
endmodule : ssr_supervisor

// ==== bench/ssr_mcu_model.sv ====
// Microcontroller side: reset wire with pull-up, push-button, watchdog kicks
`timescale 1ns/1ps
module ssr_mcu_model (
  input  wire logic i_clk,      // Clock
  input  wire logic i_drv_low,  // Supervisor pulls reset wire low
  input  wire logic i_press,    // Push-button held
  input  wire logic i_kick_en,  // Firmware alive
  output logic      o_pin,      // Resolved reset wire level
  output logic      o_kick      // Watchdog kick line
);
  logic [2:0] div_q;
  // Pull-up wins only when nobody pulls low
  assign o_pin = ~(i_drv_low | i_press);
  initial begin
    div_q = 3'h0;
    o_kick = 1'b0;
  end
  // Live firmware toggles well inside the watchdog span
  always @(posedge i_clk) begin
    div_q <= div_q + 3'h1;
    if (i_kick_en && div_q == 3'h7) begin
      o_kick <= ~o_kick;
    end
  end
endmodule : ssr_mcu_model

// ==== bench/testbench.sv ====
// Self-checking bench for the supply supervisor reset logic
`timescale 1ns/1ps
module testbench;
  import ssr_pkg::*;
  localparam int RTK = 20, WTK = 10, WDK = 50, DIV = 2;
  localparam int LO = (RTK-1)*DIV, HI = (RTK+1)*DIV+4;
  localparam int WLO = (WTK-1)*DIV, WHI = (WTK+1)*DIV+4;
  logic clk = 1'b0, rst = 1'b1, sup = 1'b1, sense = 1'b0, stop = 1'b0;
  logic press = 1'b0, kick_en = 1'b1, pin, kick;
  logic rst_n_oe, rst_oe, aux_oe, blk, abrt, busy;
  int miscompares = 0, checked = 0, seed = 32'h127ac709, n, m, k;

  initial forever #4 clk = ~clk;

  ssr_supervisor #(.RST_TK(RTK), .WR_TK(WTK), .WD_TK(WDK), .TICK_DIV(DIV)) dut_u (
    .I_CLK(clk), .I_RST(rst), .I_SUPPLY_OK(sup), .I_SENSE_LOW(sense), .I_RST_N_PIN(pin),
    .I_WDOG_KICK(kick), .I_WR_STOP(stop), .O_RST_N_OE(rst_n_oe), .O_RST_OE(rst_oe),
    .O_AUX_LOW_OE(aux_oe), .O_MEM_BLOCK(blk), .O_MEM_ABORT(abrt), .O_WR_BUSY(busy));

  ssr_mcu_model mcu_u (.i_clk(clk), .i_drv_low(rst_n_oe), .i_press(press),
    .i_kick_en(kick_en), .o_pin(pin), .o_kick(kick));

  task automatic chk(input string nm, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask : cyc

  // Bounded wait for reset drive, or write busy, to drop, counting cycles
  task automatic wait_lo(input bit on_busy, output int c);
    c = 0;
    while ((on_busy ? busy : rst_n_oe) !== 1'b0 && c < 4000) begin
      @(negedge clk);
      c++;
    end
  endtask : wait_lo

  function automatic logic in_win(input int c, input int lo, input int hi);
    return (c >= lo && c <= hi);
  endfunction : in_win

  task automatic wrap_up;
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #(8*20000);
    miscompares++;
    wrap_up();
  end

  initial begin
    cyc(12);
    rst = 1'b0;
    chk("rst_n_oe", 1'b1, rst_n_oe);
    chk("abort", 1'b1, abrt);
    wait_lo(1'b0, n);
    chk("release", 1'b1, in_win(n, LO, HI));
    chk("rst_oe", 1'b0, rst_oe);
    for (int i = 0; i < 6; i++) begin
      k = (i == 0) ? GLITCH_CYC : 1 + ({$random(seed)} % GLITCH_CYC);
      sup = 1'b0;
      cyc(k);
      sup = 1'b1;
      cyc(3);
      chk("glitch", 1'b0, rst_n_oe);
    end
    for (int i = 0; i < 24; i++) begin
      sense = 1'($random(seed));
      cyc(1);
      chk("aux_low", sense, aux_oe);
    end
    sup = 1'b0;
    cyc(8);
    chk("pd_rst_n", 1'b1, rst_n_oe);
    chk("pd_rst", 1'b1, rst_oe);
    cyc(60);
    stop = 1'b1;
    cyc(1);
    stop = 1'b0;
    cyc(1);
    chk("busy_in_rst", 1'b0, busy);
    sup = 1'b1;
    wait_lo(1'b0, n);
    chk("pd_release", 1'b1, in_win(n, LO, HI));
    // Pin must have read high for a cycle before a fall can be seen
    cyc(2);
    press = 1'b1;
    cyc(1);
    press = 1'b0;
    cyc(1);
    chk("manual", 1'b1, rst_n_oe);
    wait_lo(1'b0, n);
    chk("man_len", 1'b1, in_win(n + 2, LO, HI));
    stop = 1'b1;
    cyc(1);
    stop = 1'b0;
    chk("busy", 1'b1, busy);
    chk("block", 1'b1, blk);
    press = 1'b1;
    cyc(1);
    press = 1'b0;
    wait_lo(1'b1, m);
    chk("wr_len", 1'b1, in_win(m + 1, WLO, WHI));
    chk("abort_rst", 1'b1, abrt);
    chk("block_rst", 1'b1, blk);
    wait_lo(1'b0, n);
    chk("rel_after_wr", 1'b1, in_win(m + n, LO, HI));
    chk("unblock", 1'b0, blk);
    kick_en = 1'b0;
    cyc((WDK-2)*DIV);
    chk("wd_early", 1'b0, rst_n_oe);
    for (k = 0; k < 4*DIV+6 && rst_n_oe !== 1'b1; k++) cyc(1);
    chk("wd_fire", 1'b1, rst_n_oe);
    wait_lo(1'b0, n);
    cyc((WDK-2)*DIV);
    chk("wd_cleared", 1'b0, rst_n_oe);
    wrap_up();
  end
endmodule : testbench
